// *** pkg/dram_cfg_pkg.sv ***
// constants shared by the dram configuration and control block
// assumes a single 25 MHz clock and a synchronous active-high reset
package dram_cfg_pkg;
  // i/o port of the memory control register
  localparam logic [15:0] MEM_CTRL_PORT  = 16'h3872;
  localparam logic [15:0] MEM_CTRL_RESET = 16'h0000;
  // bit 14 is reserved: never stored, reads as zero
  localparam logic [15:0] MEM_CTRL_WMASK = 16'hBFFF;
  // field positions
  localparam int STROBE_WIDTH_BIT = 15;
  localparam int HIT_MODE_LSB     = 12;
  localparam int PAGE_MODE_BIT    = 11;
  localparam int ILV_LSB          = 8;
  // read cas width in half clocks, and the whole clocks it spans
  localparam int CAS_HALF_SLOW   = 5;
  localparam int CAS_HALF_FAST   = 4;
  localparam logic [1:0] CAS_CYCLES_SLOW = 2'((CAS_HALF_SLOW + 1) / 2);
  localparam logic [1:0] CAS_CYCLES_FAST = 2'((CAS_HALF_FAST + 1) / 2);
  // on-board disable window in 128 kbyte blocks
  localparam logic [6:0] DIS_LIMIT_BLK = 7'h05;
  localparam logic [6:0] DIS_512K_BLK  = 7'h04;
  localparam logic [6:0] DIS_256K_BLK  = 7'h02;
  localparam logic [6:0] DIS_128K_BLK  = 7'h01;
  // log2 of one bank's size in 128 kbyte units, per density step
  localparam logic [3:0] BANK_LOG_STEP = 4'h2;
  // modes of the shared pin and cache logic
  typedef enum logic [1:0] {
    HIT_OFF     = 2'b00,
    HIT_CACHE   = 2'b01,
    HIT_EXT_PAR = 2'b10,
    HIT_EXT_CLK = 2'b11
  } hit_mode_t;
  // interleave codes
  typedef enum logic [2:0] {
    ILV_NONE  = 3'b000,
    ILV_LOW   = 3'b001,
    ILV_HIGH  = 3'b010,
    ILV_BOTH  = 3'b011,
    ILV_FOUR  = 3'b100
  } ilv_t;
endpackage

// *** verilog/cas_timer.sv ***
// read/write cas pulse timer
// assumes start is a one-cycle pulse from the cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module cas_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic fast,
  // status
  output logic      active,
  output logic      trim,
  output logic      last
);
  typedef struct packed {
    logic [1:0] left;  // cycles of cas still to run
    logic       half;  // pulse ends on a half clock
  } timer_t;
  timer_t cur;
  timer_t next_cur;

  // load on start, count down while running
  always_comb begin
    next_cur = cur;
    if (start) begin
      next_cur.left = fast ? dram_cfg_pkg::CAS_CYCLES_FAST : dram_cfg_pkg::CAS_CYCLES_SLOW;
      next_cur.half = !fast;
    end else if (cur.left != 2'h0) begin
      next_cur.left = cur.left - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign active = cur.left != 2'h0;
  assign last   = cur.left == 2'h1;
  // pad releases mid-cycle in the last clock of a 2.5 clock pulse
  assign trim   = last && cur.half;
endmodule
`default_nettype wire

// *** verilog/address_mux.sv ***
// eleven-line memory address bus: row, column, chip select code, peripheral data
// assumes the select inputs are mutually exclusive per cycle
`timescale 1ns/1ps
`default_nettype none
module address_mux (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // dram phase
  input  wire logic        row_phase,
  input  wire logic        col_phase,
  input  wire logic [10:0] row_addr,
  input  wire logic [10:0] col_addr,
  // i/o phase
  input  wire logic        io_cycle,
  input  wire logic [3:0]  chip_select_code,
  input  wire logic        periph_write,
  input  wire logic [7:0]  periph_wdata,
  // bus
  output logic [10:0]      addr,
  output logic             addr_oe,
  output logic             chip_select_msb
);
  typedef struct packed {
    logic [10:0] addr;
    logic        oe;
    logic        msb;
  } mux_t;
  mux_t cur;
  mux_t next_cur;

  // pick what the bus carries next cycle
  always_comb begin
    next_cur     = cur;
    next_cur.oe  = 1'b1;
    if (row_phase) begin
      next_cur.addr = row_addr;
    end else if (col_phase) begin
      next_cur.addr = col_addr;
    end else if (io_cycle) begin
      next_cur.addr[10:8] = chip_select_code[2:0];
      next_cur.msb        = chip_select_code[3];
      next_cur.addr[7:0]  = periph_wdata;
      // the whole bus turns round when the peripheral drives data
      next_cur.oe         = periph_write;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '{addr: 11'h000, oe: 1'b1, msb: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign addr            = cur.addr;
  assign addr_oe         = cur.oe;
  assign chip_select_msb = cur.msb;

  property p_row_on_bus;
    @(posedge clk) disable iff (rst) row_phase |=> addr == $past(row_addr);
  endproperty
  a_row_on_bus: assert property (p_row_on_bus) else $error("row address not on bus");

  property p_cs_code;
    @(posedge clk) disable iff (rst)
      (io_cycle && !row_phase && !col_phase) |=>
        {chip_select_msb, addr[10:8]} == $past(chip_select_code);
  endproperty
  a_cs_code: assert property (p_cs_code) else $error("chip select code wrong");
endmodule
`default_nettype wire

// *** verilog/dram_config_control.sv ***
// dram configuration and control: memory control register, cycle sequencer,
// cas timing, write protect, on-board disable window, bank size decode
// assumes the cpu i/o strobes and memory cycle requests are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dram_config_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // cpu i/o port access
  input  wire logic [15:0] io_addr,
  input  wire logic        io_write,
  input  wire logic        io_read,
  input  wire logic [15:0] io_wdata,
  output logic [15:0]      io_rdata,
  // memory cycle request
  input  wire logic        mem_start,
  input  wire logic        mem_is_read,
  input  wire logic [23:0] mem_cpu_addr,
  input  wire logic [10:0] mem_row_addr,
  input  wire logic [10:0] mem_col_addr,
  input  wire logic        memory_write_strobe,
  input  wire logic        write_protect,
  input  wire logic [1:0]  disable_stage,
  output logic             mem_done,
  output logic             mem_abort,
  output logic             onboard_hit,
  output logic             wait_state,
  // peripheral i/o cycle
  input  wire logic        io_cycle,
  input  wire logic [3:0]  chip_select_code,
  input  wire logic        periph_write,
  input  wire logic [7:0]  periph_wdata,
  // dram pins
  output logic [10:0]      memory_mux_address,
  output logic             memory_mux_address_oe,
  output logic             chip_select_msb,
  output logic             ras,
  output logic             cas,
  output logic             cas_trim,
  // cache and shared pin
  input  wire logic        hold_ack_done,
  input  wire logic        cache_hit_ready_input,
  input  wire logic        cas_input_mode,
  input  wire logic        parity_error_internal,
  input  wire logic        parity_error_pin_in,
  output logic             parity_error_pin_out,
  output logic             parity_error_pin_oe,
  output logic             parity_error_seen,
  output logic [1:0]       hit_mode_field,
  output logic             pin_is_ready_input,
  output logic             pin_is_alt_clock,
  output logic             pin_is_parity,
  // decoded configuration
  output logic             word_interleave,
  output logic             page_interleave,
  output logic [15:0]      bank_extent_log
);
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_ROW  = 3'b010,
    ST_COL  = 3'b011,
    ST_END  = 3'b100
  } seq_t;

  typedef struct packed {
    logic [15:0]              ctrl;     // memory control register
    dram_cfg_pkg::hit_mode_t  mode;     // mode in force
    logic                     pend;     // a new mode waits for hold ack
    logic [15:0]              rdata;    // read port data
    seq_t                     st;       // cycle sequencer
    logic                     rd;       // current cycle is a read
    logic                     done;     // cycle finished pulse
    logic                     abort;    // cycle aborted pulse
    logic                     hit;      // address falls on-board
    logic                     cas;      // cas pin
    logic                     trim;     // cas ends mid-cycle
    logic                     pe_out;   // parity pin drive level
    logic                     pe_oe;    // parity pin enable
    logic                     pe_seen;  // error taken from parity pin
    logic                     wordi;    // word interleave in force
    logic                     pagei;    // page interleave in force
    logic [15:0]              extent;   // per bank log2 decoded size
    logic                     ras;      // row strobe pin
    logic                     wait_st;  // cache wait state pin
    logic                     pin_rdy;  // shared pin is ready input
    logic                     pin_alt;  // shared pin is alternate clock
    logic                     pin_par;  // shared pin is parity error
  } state_t;

  state_t cur;
  state_t next_cur;

  logic       timer_active;   // cas timer running
  logic       timer_trim;     // half-clock end in this cycle
  logic       timer_last;     // last cas cycle
  logic       timer_start;    // fire the cas timer
  logic       onboard;        // combinational on-board decode
  logic [6:0] blk;            // 128 kbyte block of the cpu address
  logic [6:0] dis_start;      // first disabled block

  cas_timer u_cas_timer (
    .clk    (clk),
    .rst    (rst),
    .start  (timer_start),
    .fast   (cur.ctrl[dram_cfg_pkg::STROBE_WIDTH_BIT] || !cur.rd),
    .active (timer_active),
    .trim   (timer_trim),
    .last   (timer_last)
  );

  address_mux u_address_mux (
    .clk              (clk),
    .rst              (rst),
    .row_phase        (cur.st == ST_ROW),
    .col_phase        (cur.st == ST_COL),
    .row_addr         (mem_row_addr),
    .col_addr         (mem_col_addr),
    .io_cycle         (io_cycle),
    .chip_select_code (chip_select_code),
    .periph_write     (periph_write),
    .periph_wdata     (periph_wdata),
    .addr             (memory_mux_address),
    .addr_oe          (memory_mux_address_oe),
    .chip_select_msb  (chip_select_msb)
  );

  // on-board disable window ends at 640k, start picked by the stage
  always_comb begin
    blk = mem_cpu_addr[23:17];
    unique case (disable_stage)
      2'b01:   dis_start = dram_cfg_pkg::DIS_512K_BLK;
      2'b10:   dis_start = dram_cfg_pkg::DIS_256K_BLK;
      2'b11:   dis_start = dram_cfg_pkg::DIS_128K_BLK;
      default: dis_start = dram_cfg_pkg::DIS_LIMIT_BLK;
    endcase
    onboard = !(blk >= dis_start && blk < dram_cfg_pkg::DIS_LIMIT_BLK);
  end

  assign timer_start = cur.st == ST_ROW;

  // next state of register, sequencer and decode
  always_comb begin
    logic [1:0] dens;
    logic [2:0] interleave_select;
    dens = 2'b00;
    interleave_select  = cur.ctrl[dram_cfg_pkg::ILV_LSB +: 3];
    next_cur       = cur;
    next_cur.done  = 1'b0;
    next_cur.abort = 1'b0;
    // mode switches only once a hold acknowledge has completed
    if (cur.pend && hold_ack_done) begin
      next_cur.mode = dram_cfg_pkg::hit_mode_t'(cur.ctrl[dram_cfg_pkg::HIT_MODE_LSB +: 2]);
      next_cur.pend = 1'b0;
    end
    // register port; reserved bit never stored
    // a write that meets the ack sets pending again, so it is not lost
    if (io_write && io_addr == dram_cfg_pkg::MEM_CTRL_PORT) begin
      next_cur.ctrl = io_wdata & dram_cfg_pkg::MEM_CTRL_WMASK;
      if (io_wdata[dram_cfg_pkg::HIT_MODE_LSB +: 2] != next_cur.mode) begin
        next_cur.pend = 1'b1;
      end
    end
    if (io_read && io_addr == dram_cfg_pkg::MEM_CTRL_PORT) begin
      next_cur.rdata = cur.ctrl;
    end
    // cycle sequencer
    unique case (cur.st)
      ST_IDLE: begin
        if (mem_start) begin
          next_cur.hit = onboard;
          next_cur.rd  = mem_is_read;
          if (onboard && mem_is_read && cur.mode == dram_cfg_pkg::HIT_CACHE) begin
            next_cur.st = ST_WAIT;
          end else if (onboard) begin
            next_cur.st = ST_ROW;
          end else begin
            next_cur.done = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (cache_hit_ready_input) begin
          next_cur.st    = ST_IDLE;
          next_cur.abort = 1'b1;
        end else begin
          next_cur.st = ST_ROW;
        end
      end
      ST_ROW: begin
        next_cur.st = ST_COL;
      end
      ST_COL: begin
        // abort a cache read that hits late, cas already timed
        if (cur.mode == dram_cfg_pkg::HIT_CACHE && cur.rd && cache_hit_ready_input) begin
          next_cur.abort = 1'b1;
          next_cur.st    = ST_END;
        end else if (timer_last) begin
          next_cur.st = ST_END;
        end
      end
      ST_END: begin
        next_cur.st   = ST_IDLE;
        next_cur.done = !cur.abort;
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
    // pin levels registered from the next state and mode
    next_cur.ras     = next_cur.st == ST_COL || next_cur.st == ST_END;
    next_cur.wait_st = next_cur.st == ST_WAIT;
    next_cur.pin_rdy = next_cur.mode == dram_cfg_pkg::HIT_CACHE;
    next_cur.pin_par = next_cur.mode == dram_cfg_pkg::HIT_EXT_PAR;
    next_cur.pin_alt = next_cur.mode == dram_cfg_pkg::HIT_OFF ||
                       next_cur.mode == dram_cfg_pkg::HIT_EXT_CLK;
    // cas withheld for the whole write strobe of a protected write
    next_cur.cas  = timer_active && !next_cur.abort &&
                    !(write_protect && memory_write_strobe);
    next_cur.trim = timer_trim && next_cur.cas;
    // parity pin turns into an input in mode 11 with cas input mode
    next_cur.pe_oe   = !(cur.mode == dram_cfg_pkg::HIT_EXT_CLK && cas_input_mode);
    next_cur.pe_out  = parity_error_internal;
    next_cur.pe_seen = !next_cur.pe_oe && parity_error_pin_in;
    // interleave style follows the page bit
    next_cur.wordi = interleave_select != 3'b000 && !cur.ctrl[dram_cfg_pkg::PAGE_MODE_BIT];
    next_cur.pagei = interleave_select != 3'b000 && cur.ctrl[dram_cfg_pkg::PAGE_MODE_BIT];
    // per bank decoded size, raised by its interleave grouping
    for (int b = 0; b < 4; b++) begin
      dens = cur.ctrl[2*b +: 2];
      next_cur.extent[4*b +: 4] = 4'(dens * dram_cfg_pkg::BANK_LOG_STEP);
      if (interleave_select == dram_cfg_pkg::ILV_FOUR) begin
        next_cur.extent[4*b +: 4] = 4'(dens * dram_cfg_pkg::BANK_LOG_STEP + 4'h2);
      end else if ((b < 2 && (interleave_select == dram_cfg_pkg::ILV_LOW || interleave_select == dram_cfg_pkg::ILV_BOTH)) ||
                   (b >= 2 && (interleave_select == dram_cfg_pkg::ILV_HIGH || interleave_select == dram_cfg_pkg::ILV_BOTH))) begin
        next_cur.extent[4*b +: 4] = 4'(dens * dram_cfg_pkg::BANK_LOG_STEP + 4'h1);
      end
    end
  end

  // whole state registered; reset clears every field except pe_oe and pin_alt, which it sets
  always_ff @(posedge clk) begin
    if (rst) begin
      cur       <= '0;
      cur.ctrl  <= dram_cfg_pkg::MEM_CTRL_RESET;
      cur.mode  <= dram_cfg_pkg::HIT_OFF;
      cur.st    <= ST_IDLE;
      cur.pe_oe <= 1'b1;
      cur.pin_alt <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs, all from flops
  assign io_rdata             = cur.rdata;
  assign mem_done             = cur.done;
  assign mem_abort            = cur.abort;
  assign onboard_hit          = cur.hit;
  assign wait_state           = cur.wait_st;
  assign ras                  = cur.ras;
  assign cas                  = cur.cas;
  assign cas_trim             = cur.trim;
  assign parity_error_pin_out = cur.pe_out;
  assign parity_error_pin_oe  = cur.pe_oe;
  assign parity_error_seen    = cur.pe_seen;
  assign hit_mode_field       = cur.mode;
  // shared pin role from the mode in force
  assign pin_is_ready_input   = cur.pin_rdy;
  assign pin_is_parity        = cur.pin_par;
  assign pin_is_alt_clock     = cur.pin_alt;
  assign word_interleave      = cur.wordi;
  assign page_interleave      = cur.pagei;
  assign bank_extent_log      = cur.extent;

  property p_wp_no_cas;
    @(posedge clk) disable iff (rst) (write_protect && memory_write_strobe) |=> !cas;
  endproperty
  a_wp_no_cas: assert property (p_wp_no_cas) else $error("cas during protected write");

  property p_slow_cas;
    @(posedge clk) disable iff (rst)
      ($rose(cas) && cur.rd && !cur.ctrl[15] && !write_protect && !cache_hit_ready_input)
        |-> cas [*3] ##0 cas_trim;
  endproperty
  a_slow_cas: assert property (p_slow_cas) else $error("slow read cas not 2.5 clocks");

  property p_fast_cas;
    @(posedge clk) disable iff (rst)
      ($rose(cas) && cur.ctrl[15]) |-> !cas_trim ##2 !cas;
  endproperty
  a_fast_cas: assert property (p_fast_cas) else $error("fast cas not 2 clocks");

  property p_cache_wait;
    @(posedge clk) disable iff (rst)
      (mem_start && !wait_state && !ras && mem_is_read && onboard &&
       hit_mode_field == 2'b01 && cur.st == ST_IDLE) |=> wait_state ##1 !ras;
  endproperty
  a_cache_wait: assert property (p_cache_wait) else $error("no cache wait state");

  property p_hit_abort;
    @(posedge clk) disable iff (rst)
      (wait_state && cache_hit_ready_input) |=> mem_abort && !ras ##1 !cas;
  endproperty
  a_hit_abort: assert property (p_hit_abort) else $error("hit did not abort read");

  property p_mode_held;
    @(posedge clk) disable iff (rst) !hold_ack_done |=> $stable(hit_mode_field);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed without hold ack");

  property p_parity_input;
    @(posedge clk) disable iff (rst)
      (hit_mode_field == 2'b11 && cas_input_mode) |=> !parity_error_pin_oe;
  endproperty
  a_parity_input: assert property (p_parity_input) else $error("parity pin still driven");

  property p_disabled_window;
    @(posedge clk) disable iff (rst)
      (mem_start && cur.st == ST_IDLE && !onboard) |=> mem_done && !onboard_hit ##1 !ras;
  endproperty
  a_disabled_window: assert property (p_disabled_window) else $error("disabled memory used");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst) io_rdata[14] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_page_ilv;
    @(posedge clk) disable iff (rst) !(word_interleave && page_interleave);
  endproperty
  a_page_ilv: assert property (p_page_ilv) else $error("both interleave styles");

  c_read_cycle: cover property (@(posedge clk) disable iff (rst) mem_done && cur.rd);
  c_abort:      cover property (@(posedge clk) disable iff (rst) mem_abort);
  c_mode_swap:  cover property (@(posedge clk) disable iff (rst) $changed(hit_mode_field));
  c_protect:    cover property (@(posedge clk) disable iff (rst) write_protect && memory_write_strobe && ras);
endmodule
`default_nettype wire

// *** testbench/dram_bank_model.sv ***
// dram bank model: takes row and column off the multiplexed bus
// assumes active-high ras and cas that change after the rising edge
`timescale 1ns/1ps
`default_nettype none
module dram_bank_model (
  // clock
  input  wire logic        clk,
  // strobes and bus
  input  wire logic        ras,
  input  wire logic        cas,
  input  wire logic        cas_trim,
  input  wire logic [10:0] addr,
  // what the bank saw
  output logic      [10:0] row_seen,
  output logic      [10:0] col_seen,
  output logic      [3:0]  cas_len,
  output logic             trim_seen
);
  logic ras_q;  // previous ras
  logic cas_q;  // previous cas
  // a real bank latches on the strobe edge, so a late bus value is missed
  always @(posedge clk) begin
    if (ras && !ras_q) begin
      row_seen <= addr;
      cas_len <= 4'h0;
      trim_seen <= 1'b0;
    end else if (ras && cas) begin
      cas_len <= cas_len + 4'h1;
      trim_seen <= trim_seen | cas_trim;
    end
    if (cas && !cas_q)
      col_seen <= addr;
    ras_q <= ras;
    cas_q <= cas;
  end
endmodule
`default_nettype wire

// *** testbench/dram_config_control_test.sv ***
// self-checking bench for the dram configuration block
// assumes the bank model file and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module dram_config_control_test;
  // stimulus
  logic clk = 0, rst = 1, io_write = 0, io_read = 0, mem_start = 0;
  logic mem_is_read = 0, memory_write_strobe = 0, write_protect = 0;
  logic io_cycle = 0, periph_write = 0, hold_ack_done = 0;
  logic cache_hit_ready_input = 0, parity_error_pin_in = 0;
  logic cas_input_mode = 1, parity_error_internal = 0;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000;
  logic [23:0] mem_cpu_addr = 24'h00_0000;
  logic [10:0] mem_row_addr = 11'h000, mem_col_addr = 11'h000;
  logic [1:0]  disable_stage = 2'b00;
  logic [3:0]  chip_select_code = 4'h0;
  logic [7:0]  periph_wdata = 8'h00;
  // design outputs and model view
  logic [15:0] io_rdata, bank_extent_log;
  logic [10:0] memory_mux_address, m_row, m_col;
  logic [1:0]  hit_mode_field;
  logic [3:0]  m_len;
  logic mem_done, mem_abort, onboard_hit, wait_state, m_trim;
  logic memory_mux_address_oe, chip_select_msb, ras, cas, cas_trim;
  logic parity_error_pin_out, parity_error_pin_oe, parity_error_seen;
  logic pin_is_ready_input, pin_is_alt_clock, pin_is_parity;
  logic word_interleave, page_interleave;
  int   err_count = 0, checks_done = 0;
  // shared pin state as one word
  wire  [15:0] pin_vec = {8'h00, parity_error_pin_oe, parity_error_pin_out,
                          hit_mode_field, pin_is_ready_input,
                          pin_is_alt_clock, pin_is_parity, parity_error_seen};
  always #20 clk = ~clk;
  dram_config_control i_dut (.*);
  dram_bank_model i_bank (.clk(clk), .ras(ras), .cas(cas),
    .cas_trim(cas_trim), .addr(memory_mux_address), .row_seen(m_row),
    .col_seen(m_col), .cas_len(m_len), .trim_seen(m_trim));
  // verdict, also reached from a stuck wait
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // register port write; ends settled on a falling edge
  task automatic io_wr(input logic [15:0] a, d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_write <= 1'b1;
    @(posedge clk);
    io_write <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    io_addr <= a;
    io_read <= 1'b1;
    @(posedge clk);
    io_read <= 1'b0;
    @(negedge clk);
    d = io_rdata;
  endtask
  task automatic ack;
    @(posedge clk);
    hold_ack_done <= 1'b1;
    @(posedge clk);
    hold_ack_done <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // one memory cycle, bounded wait for done or abort
  task automatic mem(input logic rd, input logic [23:0] a, output logic ab, ws);
    int i;
    ws = 0;
    @(posedge clk);
    mem_start <= 1'b1;
    mem_is_read <= rd;
    mem_cpu_addr <= a;
    @(posedge clk);
    mem_start <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      ws |= (wait_state === 1'b1);
      if (mem_done === 1'b1 || mem_abort === 1'b1)
        break;
    end
    ab = (mem_abort === 1'b1);
    if (i == 20) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic t_reg;
    logic [15:0] d;
    io_rd(16'h3872, d);
    chk("ctrl", 16'h0000, d);
    chk("extent", 16'h0000, bank_extent_log);
    io_wr(16'h3872, 16'hbfff);
    io_rd(16'h3872, d);
    chk("ctrl", 16'hbfff, d);
    io_wr(16'h3873, 16'h0000);
    io_rd(16'h3872, d);
    chk("ctrl stray", 16'hbfff, d);
    $display("test reg done");
  endtask
  task automatic t_cfg;
    io_wr(16'h3872, 16'h0cff);
    chk("extent", 16'h8888, bank_extent_log);
    chk("ilv", 16'h0001, {14'h0, word_interleave, page_interleave});
    io_wr(16'h3872, 16'h011a);
    chk("extent", 16'h0255, bank_extent_log);
    chk("ilv", 16'h0002, {14'h0, word_interleave, page_interleave});
    $display("test cfg done");
  endtask
  task automatic t_mode;
    logic [1:0]  md [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
    logic [15:0] ex [4] = '{16'h0098, 16'h00e2, 16'h0035, 16'h0084};
    logic [15:0] prev;
    prev = 16'h0084;
    for (int k = 0; k < 4; k++) begin
      io_wr(16'h3872, {2'b00, md[k], 12'h000});
      chk("mode held", prev, pin_vec);
      @(posedge clk);
      parity_error_pin_in <= (k == 2);
      parity_error_internal <= (k == 1);
      ack();
      chk("mode", ex[k], pin_vec);
      prev = ex[k];
    end
    $display("test mode done");
  endtask
  task automatic t_cache;
    logic ab, ws;
    io_wr(16'h3872, 16'h1000);
    ack();
    @(posedge clk);
    cache_hit_ready_input <= 1'b1;
    mem(1'b1, 24'h00_0000, ab, ws);
    chk("abort", 16'h0001, {15'h0, ab});
    @(posedge clk);
    cache_hit_ready_input <= 1'b0;
    mem(1'b1, 24'h00_0000, ab, ws);
    chk("wait", 16'h0001, {14'h0, ab, ws});
    chk("cas", 16'h0013, {11'h0, m_trim, m_len});
    io_wr(16'h3872, 16'h0000);
    ack();
    $display("test cache done");
  endtask
  task automatic t_mem;
    logic ab, ws;
    logic [23:0] lo [3] = '{24'h08_0000, 24'h04_0000, 24'h02_0000};
    @(posedge clk);
    mem_row_addr <= 11'h5a3;
    mem_col_addr <= 11'h2c4;
    mem(1'b1, 24'h00_0000, ab, ws);
    chk("row", 16'h05a3, {5'h0, m_row});
    chk("col", 16'h02c4, {5'h0, m_col});
    chk("cas", 16'h0013, {11'h0, m_trim, m_len});
    io_wr(16'h3872, 16'h8000);
    mem(1'b1, 24'h00_0000, ab, ws);
    chk("cas fast", 16'h0002, {11'h0, m_trim, m_len});
    @(posedge clk);
    memory_write_strobe <= 1'b1;
    mem(1'b0, 24'h00_0000, ab, ws);
    chk("cas wr", 16'h0002, {11'h0, m_trim, m_len});
    @(posedge clk);
    write_protect <= 1'b1;
    mem(1'b0, 24'h00_0000, ab, ws);
    chk("cas wp", 16'h0000, {11'h0, m_trim, m_len});
    @(posedge clk);
    write_protect <= 1'b0;
    memory_write_strobe <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      disable_stage <= 2'(s + 1);
      mem(1'b1, lo[s], ab, ws);
      chk("off", 16'h0000, {15'h0, onboard_hit});
      mem(1'b1, lo[s] - 24'h00_0001, ab, ws);
      chk("on", 16'h0001, {15'h0, onboard_hit});
    end
    $display("test mem done");
  endtask
  task automatic t_io;
    @(posedge clk);
    io_cycle <= 1'b1;
    chip_select_code <= 4'hb;
    periph_write <= 1'b1;
    periph_wdata <= 8'ha5;
    repeat (3) @(negedge clk);
    chk("bus", 16'h1ba5, {3'h0, memory_mux_address_oe, chip_select_msb,
        memory_mux_address});
    @(posedge clk);
    periph_write <= 1'b0;
    repeat (2) @(negedge clk);
    chk("oe", 16'h0000, {15'h0, memory_mux_address_oe});
    $display("test io done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_cfg();
    t_mode();
    t_cache();
    t_mem();
    t_io();
    complete_run();
  end
endmodule
`default_nettype wire
